// [logic/eiesv_cfg.svh]
`ifndef EIESV_CFG_SVH
`define EIESV_CFG_SVH

// register byte offsets
`define EIESV_OFF_ENABLE 8'h00
`define EIESV_OFF_SENSE 8'h04
`define EIESV_OFF_STATUS 8'h08
`define EIESV_OFF_PRIO1 8'h0C
`define EIESV_OFF_PRIO2 8'h10
`define EIESV_OFF_SYSCTL 8'h14
`define EIESV_ADDR_W 8

// reset values
`define EIESV_RST_BYTE 8'h00
`define EIESV_RST_WORD 32'h0000_0000

// field positions
`define EIESV_LINES 6
`define EIESV_SYS_NMI_RISE 0
`define EIESV_SYS_ADVANCED 1
`define EIESV_P1_LINE0 7
`define EIESV_P1_LINE1 6
`define EIESV_P1_LINE23 5
`define EIESV_P1_LINE45 4
`define EIESV_P1_WDOG_CONV 3
`define EIESV_P1_TMR0 2
`define EIESV_P1_TMR1 1
`define EIESV_P1_TMR2 0
`define EIESV_P2_T8_01 7
`define EIESV_P2_T8_23 6
`define EIESV_P2_SCI0 3
`define EIESV_P2_SCI1 2

// vector numbers
`define EIESV_VEC_NMI 6'h07
`define EIESV_VEC_LINE0 12
`define EIESV_VEC_WDOG 20
`define EIESV_VEC_CONV 23
`define EIESV_VEC_TMR0 24
`define EIESV_VEC_TMR1 28
`define EIESV_VEC_TMR2 32
`define EIESV_VEC_T8_01 36
`define EIESV_VEC_T8_23 40
`define EIESV_VEC_SCI0 52
`define EIESV_VEC_SCI1 56
`define EIESV_NUM_PERIPH 27

`endif

// [logic/eiesv_pkg.sv]
`include "eiesv_cfg.svh"

package eiesv_pkg;

    // whole state of the front end
    typedef struct packed {
        logic [7:0] enable;
        logic [7:0] sense;
        logic [5:0] flag;
        logic [5:0] seen;
        logic [7:0] prio1;
        logic [7:0] prio2;
        logic [7:0] sysctl;
        logic [5:0] sync1;
        logic [5:0] sync2;
        logic [5:0] prev;
        logic nsync1;
        logic nsync2;
        logic nprev;
        logic nmi_pend;
        logic [31:0] rdata;
        logic err;
        logic req_valid;
        logic req_nmi;
        logic req_high;
        logic [7:0] req_vec;
        logic [15:0] req_addr;
    } eiesv_state_t;

endpackage

// [logic/eiesv_top.sv]
`timescale 1ns/1ps
`include "eiesv_cfg.svh"

// Summary of operation
// - enable register, 8 bits, clears on reset/standby
// - enable bits 7,6 stored, no effect
// - enable bits 5..0 gate lines 5..0
// - sense register, 8 bits, clears on reset/standby
// - sense bits 7,6 stored, no effect
// - sense 0 low level, 1 falling edge
// - nmi highest, ignores cpu masks
// - edge select picks nmi rising or falling
// - nmi uses vector 7
// - lines 0..5 use vectors 12..17
// - detection independent of pin direction
// - first priority bits 7..4 rank lines
// - equal level, smaller vector wins
// - after reset default vector order
// - all but nmi reprioritisable, nmi fixed
// - status shows pending lines, software clears
// - seven external plus 27 peripheral sources
// - peripherals gate their own requests
// - fixed peripheral vector map, reserved gaps
// - vector address times four or two
// - one bit ranks watchdog and converter
// - flag clears by read-then-0 or exception

module eiesv_top
    import eiesv_pkg::*;
(
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, low
    input wire logic hw_standby, // standby entry, clears regs
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [`EIESV_ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [5:0] irq_n_pin, // request pins, low active
    input wire logic nmi_pin, // nonmaskable pin
    input wire logic [26:0] periph_req, // enabled peripheral lines
    input wire logic cpu_mask, // cpu blocks maskable
    input wire logic cpu_ack, // exception taken pulse
    input wire logic [7:0] cpu_ack_vec, // vector being taken
    output logic req_valid, // request to cpu
    output logic req_nmi, // request is nmi
    output logic req_high, // request at level 1
    output logic [7:0] req_vec, // vector number
    output logic [15:0] req_addr // vector fetch address
);

    ////////////////////////////////////////////////////////////
    // state and helpers
    // all state lives in one packed struct; the next-state copy is
    // filled by one process and registered by one flop process

    eiesv_state_t st_r; // registered state
    eiesv_state_t st_nxt; // next state
    logic [63:0] src_req; // requests by vector
    logic [63:0] src_high; // level 1 by vector
    logic [6:0] pick; // found flag and vector

    // two winners are tracked in one loop: the level 1 winner and the
    // plain winner, so a level 1 source always beats any level 0 source
    // whatever its vector number
    // the loop runs downward so the last hit is the smallest vector,
    // which gives the fixed tie-break inside one level
    // cost: a 64-wide priority chain, fine at this clock
    // lowest vector at level 1 first, else lowest overall
    function automatic logic [6:0] arbitrate(input logic [63:0] rq, input logic [63:0] hi);
        logic [5:0] best_hi;
        logic [5:0] best_any;
        logic fh;
        logic fa;
        best_hi = 6'h00;
        best_any = 6'h00;
        fh = 1'b0;
        fa = 1'b0;
        for (int i = 63; i >= 0; i--) begin
            if (rq[i] && hi[i]) begin
                best_hi = 6'(i);
                fh = 1'b1;
            end
            if (rq[i]) begin
                best_any = 6'(i);
                fa = 1'b1;
            end
        end
        if (fh) begin
            return {1'b1, best_hi};
        end
        return {fa, best_any};
    endfunction

    // only the low 16 bits of the fetch address are produced; the cpu
    // adds any upper bits itself
    // advanced mode spends four bytes a vector, normal mode two
    // fetch address from vector and mode
    function automatic logic [15:0] vec_addr(input logic [5:0] v, input logic adv);
        if (adv) begin
            return {8'h00, v, 2'b00};
        end
        return {9'h000, v, 1'b0};
    endfunction

    ////////////////////////////////////////////////////////////
    // source map by vector number

    // one bit per vector number keeps the map readable: a source sits at
    // the index of its own vector, so arbitration needs no lookup table
    // vectors 18, 19, 21, 22, 27 and 31 are never driven here
    // the cpu mask blocks every maskable source; nmi is not in this map
    // reserved vectors stay zero; the peripherals already
    // applied their own enables, so only ranking happens here
    always_comb begin
        src_req = 64'h0000_0000_0000_0000;
        src_high = 64'h0000_0000_0000_0000;
        for (int n = 0; n < `EIESV_LINES; n++) begin
            src_req[`EIESV_VEC_LINE0 + n] = st_r.flag[n] & st_r.enable[n] & ~cpu_mask;
        end
        // line levels: lines 2,3 and lines 4,5 share a bit
        src_high[`EIESV_VEC_LINE0] = st_r.prio1[`EIESV_P1_LINE0];
        src_high[`EIESV_VEC_LINE0 + 1] = st_r.prio1[`EIESV_P1_LINE1];
        src_high[`EIESV_VEC_LINE0 + 2] = st_r.prio1[`EIESV_P1_LINE23];
        src_high[`EIESV_VEC_LINE0 + 3] = st_r.prio1[`EIESV_P1_LINE23];
        src_high[`EIESV_VEC_LINE0 + 4] = st_r.prio1[`EIESV_P1_LINE45];
        src_high[`EIESV_VEC_LINE0 + 5] = st_r.prio1[`EIESV_P1_LINE45];
        // each peripheral already gated its own request with its enable
        // peripheral requests, masked by the cpu as well
        if (!cpu_mask) begin
            src_req[`EIESV_VEC_WDOG] = periph_req[0];
            src_req[`EIESV_VEC_CONV] = periph_req[1];
            src_req[`EIESV_VEC_TMR0 +: 3] = periph_req[4:2];
            src_req[`EIESV_VEC_TMR1 +: 3] = periph_req[7:5];
            src_req[`EIESV_VEC_TMR2 +: 3] = periph_req[10:8];
            src_req[`EIESV_VEC_T8_01 +: 4] = periph_req[14:11];
            src_req[`EIESV_VEC_T8_23 +: 4] = periph_req[18:15];
            src_req[`EIESV_VEC_SCI0 +: 4] = periph_req[22:19];
            src_req[`EIESV_VEC_SCI1 +: 4] = periph_req[26:23];
        end
        // peripheral levels: one priority bit covers a whole group
        // reserved priority bits are stored and have no effect
        src_high[`EIESV_VEC_WDOG] = st_r.prio1[`EIESV_P1_WDOG_CONV];
        src_high[`EIESV_VEC_CONV] = st_r.prio1[`EIESV_P1_WDOG_CONV];
        src_high[`EIESV_VEC_TMR0 +: 3] = {3{st_r.prio1[`EIESV_P1_TMR0]}};
        src_high[`EIESV_VEC_TMR1 +: 3] = {3{st_r.prio1[`EIESV_P1_TMR1]}};
        src_high[`EIESV_VEC_TMR2 +: 3] = {3{st_r.prio1[`EIESV_P1_TMR2]}};
        src_high[`EIESV_VEC_T8_01 +: 4] = {4{st_r.prio2[`EIESV_P2_T8_01]}};
        src_high[`EIESV_VEC_T8_23 +: 4] = {4{st_r.prio2[`EIESV_P2_T8_23]}};
        src_high[`EIESV_VEC_SCI0 +: 4] = {4{st_r.prio2[`EIESV_P2_SCI0]}};
        src_high[`EIESV_VEC_SCI1 +: 4] = {4{st_r.prio2[`EIESV_P2_SCI1]}};
        // winner among the maskable sources
        pick = arbitrate(src_req, src_high);
    end

    ////////////////////////////////////////////////////////////
    // next state

    // a single next-state process keeps every field of the state struct
    // in one place, so no field can end up with two drivers
    // order inside matters: clears are gathered first, then the set
    // terms are merged in, so an event in a clearing cycle survives
    // one process for bus, detection, flags and the registered request outputs
    always_comb begin
        logic setup;
        logic wr;
        logic rd;
        logic [5:0] fall;
        logic [5:0] set_f;
        logic [5:0] clr_f;
        logic nmi_edge;
        logic ack_line;
        logic [2:0] ack_idx;
        setup = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        fall = 6'h00;
        set_f = 6'h00;
        clr_f = 6'h00;
        nmi_edge = 1'b0;
        ack_line = 1'b0;
        ack_idx = 3'h0;
        st_nxt = st_r;

        // the pins are asynchronous to pclk; two flops cut metastability
        // before any decision is made on them
        // sync holds the pin inverted so that 1 means a request level,
        // and the reset value 0 matches an idle high pin: no false edge
        // pin synchronisers; only sync2 is looked at
        st_nxt.sync1 = ~irq_n_pin;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.prev = st_r.sync2;
        st_nxt.nsync1 = ~nmi_pin; // inverted, reset 0 is the idle-high pin
        st_nxt.nsync2 = st_r.nsync1;
        st_nxt.nprev = st_r.nsync2;

        // level mode copies the request level every cycle; edge mode
        // needs one high-to-low step between two samples
        // the pin's port direction is not an input of this block at all
        // pins are sensed the same whatever their direction
        fall = st_r.sync2 & ~st_r.prev;
        for (int n = 0; n < `EIESV_LINES; n++) begin
            if (st_r.sense[n]) begin
                set_f[n] = fall[n];
            end else begin
                set_f[n] = st_r.sync2[n];
            end
        end

        // nmi edge, polarity from system control
        // nsync is held inverted, so a falling pin shows as a rising
        // nsync; reset 0 then matches the idle-high pin and no false
        // edge follows reset or a change of the select bit
        if (st_r.sysctl[`EIESV_SYS_NMI_RISE]) begin
            nmi_edge = ~st_r.nsync2 & st_r.nprev;
        end else begin
            nmi_edge = st_r.nsync2 & ~st_r.nprev;
        end

        // only vectors 12..17 touch the line flags; any other taken
        // vector leaves them alone
        // exception taken clears the matching flag
        if (cpu_ack && cpu_ack_vec >= 8'(`EIESV_VEC_LINE0)
            && cpu_ack_vec < 8'(`EIESV_VEC_LINE0 + `EIESV_LINES)) begin
            ack_line = 1'b1;
            ack_idx = 3'(cpu_ack_vec - 8'(`EIESV_VEC_LINE0));
        end
        if (ack_line) begin
            // level mode needs the pin back high first
            if (st_r.sense[ack_idx] || !st_r.sync2[ack_idx]) begin
                clr_f[ack_idx] = 1'b1;
            end
        end

        // decoding in the setup cycle lets the access cycle answer at
        // once with pready tied high: zero wait states for every register
        // limitation: a register changed during setup of a read is shown
        // with its old value
        // unmapped offsets raise the error flag and block the write
        // apb: read data captured in setup, acts at access
        setup = psel && !penable;
        wr = psel && penable && pwrite;
        rd = psel && penable && !pwrite;
        if (setup) begin
            st_nxt.err = 1'b0;
            st_nxt.rdata = `EIESV_RST_WORD;
            unique case (paddr)
                `EIESV_OFF_ENABLE: st_nxt.rdata[7:0] = st_r.enable;
                `EIESV_OFF_SENSE: st_nxt.rdata[7:0] = st_r.sense;
                `EIESV_OFF_STATUS: st_nxt.rdata[5:0] = st_r.flag;
                `EIESV_OFF_PRIO1: st_nxt.rdata[7:0] = st_r.prio1;
                `EIESV_OFF_PRIO2: st_nxt.rdata[7:0] = st_r.prio2;
                `EIESV_OFF_SYSCTL: st_nxt.rdata[7:0] = st_r.sysctl;
                default: st_nxt.err = 1'b1;
            endcase
        end

        // seen remembers which flags software has read as 1; a later write
        // of 0 may clear only those, so a flag raised after the read
        // cannot be lost by a blind clear
        // a status read marks the flags seen as 1
        if (rd && !st_r.err && paddr == `EIESV_OFF_STATUS) begin
            st_nxt.seen = st_r.seen | st_r.rdata[5:0];
        end

        // writes land at the access edge; spare bits of every register but status
        // are stored and read back but steer nothing
        if (wr && !st_r.err) begin
            unique case (paddr)
                `EIESV_OFF_ENABLE: st_nxt.enable = pwdata[7:0];
                `EIESV_OFF_SENSE: st_nxt.sense = pwdata[7:0];
                `EIESV_OFF_STATUS: begin
                    // only a 0 onto a flag seen as 1 clears it
                    clr_f = clr_f | (~pwdata[5:0] & st_r.seen & st_r.flag);
                    st_nxt.seen = st_r.seen & pwdata[5:0];
                end
                `EIESV_OFF_PRIO1: st_nxt.prio1 = pwdata[7:0];
                `EIESV_OFF_PRIO2: st_nxt.prio2 = pwdata[7:0];
                `EIESV_OFF_SYSCTL: st_nxt.sysctl = pwdata[7:0];
                default: begin
                end
            endcase
        end

        // seen bits follow their flags down so a stale mark never
        // outlives the flag it belongs to
        // a new event in the clearing cycle is kept
        st_nxt.flag = (st_r.flag & ~clr_f) | set_f;
        st_nxt.seen = st_nxt.seen & st_nxt.flag;

        // a second edge that lands in the taking cycle is kept, so no
        // nonmaskable event is lost in the taking cycle
        // nmi pending: set wins over the taking cycle
        if (cpu_ack && cpu_ack_vec == {2'b00, `EIESV_VEC_NMI}) begin
            st_nxt.nmi_pend = 1'b0;
        end
        if (nmi_edge) begin
            st_nxt.nmi_pend = 1'b1;
        end

        // the request outputs are registered: they trail the flags by
        // one edge, which the cpu side must allow for
        // nmi bypasses the cpu mask and outranks all
        if (st_r.nmi_pend) begin
            st_nxt.req_valid = 1'b1;
            st_nxt.req_nmi = 1'b1;
            st_nxt.req_high = 1'b1;
            st_nxt.req_vec = {2'b00, `EIESV_VEC_NMI};
            st_nxt.req_addr = vec_addr(`EIESV_VEC_NMI, st_r.sysctl[`EIESV_SYS_ADVANCED]);
        end else begin
            // no nmi: the arbitration winner, or all zero when idle
            st_nxt.req_valid = pick[6];
            st_nxt.req_nmi = 1'b0;
            st_nxt.req_high = pick[6] & src_high[pick[5:0]];
            st_nxt.req_vec = pick[6] ? {2'b00, pick[5:0]} : 8'h00;
            st_nxt.req_addr = pick[6] ? vec_addr(pick[5:0], st_r.sysctl[`EIESV_SYS_ADVANCED]) : 16'h0000;
        end

        // standby is a synchronous clear, unlike presetn; the synchroniser
        // flops are left running so the pins are tracked again at once
        // when standby ends
        // standby forces the registers back to reset
        if (hw_standby) begin
            st_nxt.enable = `EIESV_RST_BYTE;
            st_nxt.sense = `EIESV_RST_BYTE;
            st_nxt.flag = 6'h00;
            st_nxt.seen = 6'h00;
            st_nxt.prio1 = `EIESV_RST_BYTE;
            st_nxt.prio2 = `EIESV_RST_BYTE;
            st_nxt.sysctl = `EIESV_RST_BYTE;
            st_nxt.nmi_pend = 1'b0;
            st_nxt.req_valid = 1'b0;
            st_nxt.req_nmi = 1'b0;
            st_nxt.req_high = 1'b0;
            st_nxt.req_vec = 8'h00;
            st_nxt.req_addr = 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////
    // state register

    // asynchronous reset to all zeros: registers at their reset values,
    // request outputs idle, synchronisers at the idle pin level
    // reset loads constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////
    // outputs

    // every data output comes straight from a flop of the state struct;
    // only the handshake outputs pready and pslverr are combinational
    // zero wait states; read data already captured in setup
    assign pready = 1'b1;
    assign pslverr = psel & penable & st_r.err;
    assign prdata = st_r.rdata;
    assign req_valid = st_r.req_valid;
    assign req_nmi = st_r.req_nmi;
    assign req_high = st_r.req_high;
    assign req_vec = st_r.req_vec;
    assign req_addr = st_r.req_addr;

endmodule

// [sim/eiesv_asserts.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// watches the request side and the read lanes of the front end
module eiesv_asserts (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, low
    input wire logic hw_standby, // standby level
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire logic [31:0] prdata, // read data
    input wire logic cpu_mask, // maskable block
    input wire logic req_valid, // request out
    input wire logic req_nmi, // nmi marker
    input wire logic [7:0] req_vec, // vector out
    input wire logic [15:0] req_addr // fetch address
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_nmi_vector: assert property (req_nmi |-> req_valid && req_vec == 8'h07)
        else $error("nmi vector wrong");
    a_nmi_address: assert property (req_nmi |-> req_addr inside {16'h001C, 16'h000E})
        else $error("nmi address wrong");
    a_addr_scale: assert property (req_valid |->
        req_addr == {7'h00, req_vec, 1'b0} || req_addr == {6'h00, req_vec, 2'b00})
        else $error("vector address not scaled");
    a_idle_zero: assert property (!req_valid |-> req_vec == 8'h00 && req_addr == 16'h0000 && !req_nmi)
        else $error("idle outputs not zero");
    a_vec_map: assert property (req_valid && !req_nmi |->
        req_vec inside {[12:17], 20, 23, [24:26], [28:30], [32:34], [36:43], [52:59]})
        else $error("vector outside map");
    // mask is sampled at the edge that loads the request, hence the past
    a_mask_holds: assert property ($past(cpu_mask) |-> !req_valid || req_nmi)
        else $error("maskable request passed mask");
    a_standby_quiet: assert property (hw_standby |=> !req_valid)
        else $error("request during standby");
    a_read_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read lanes not zero");
    c_nmi: cover property (req_nmi);
    c_line0: cover property (req_valid && req_vec == 8'h0C);
    c_wdog: cover property (req_valid && req_vec == 8'h14);
endmodule

bind eiesv_top eiesv_asserts u_chk (.pclk(pclk), .presetn(presetn), .hw_standby(hw_standby),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .cpu_mask(cpu_mask),
    .req_valid(req_valid), .req_nmi(req_nmi), .req_vec(req_vec), .req_addr(req_addr));

// [sim/eiesv_cpu_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// cpu side: takes the offered request when allowed, one pulse
module eiesv_cpu_model (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, low
    input wire logic take_en, // bench lets cpu take
    input wire logic req_valid, // request offered
    input wire logic [7:0] req_vec, // offered vector
    output logic cpu_ack, // taken pulse
    output logic [7:0] cpu_ack_vec // taken vector
);
    logic [1:0] gap_r; // gap so a cleared source drops first
    // ack pulse; vector is junk outside it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_ack <= 1'b0;
            cpu_ack_vec <= 8'h00;
            gap_r <= 2'h0;
        end else if (take_en && req_valid && gap_r == 2'h0) begin
            cpu_ack <= 1'b1;
            cpu_ack_vec <= req_vec;
            gap_r <= 2'h3;
        end else begin
            cpu_ack <= 1'b0;
            cpu_ack_vec <= ~cpu_ack_vec;
            gap_r <= (gap_r == 2'h0) ? 2'h0 : gap_r - 2'h1;
        end
    end
endmodule

// [sim/external_irq_enable_sense_vectors_tb.sv]
`timescale 1ns/1ps
`include "eiesv_cfg.svh"
module external_irq_enable_sense_vectors_tb import eiesv_pkg::*;;
    localparam logic [7:0] r_en = `EIESV_OFF_ENABLE;
    localparam logic [7:0] r_sc = `EIESV_OFF_SENSE;
    localparam logic [7:0] r_st = `EIESV_OFF_STATUS;
    localparam logic [7:0] r_p1 = `EIESV_OFF_PRIO1;
    localparam logic [7:0] r_p2 = `EIESV_OFF_PRIO2;
    localparam logic [7:0] r_sy = `EIESV_OFF_SYSCTL;
    logic pclk = 1'b0, presetn = 1'b0, hw_standby = 1'b0; // clock, reset
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb controls
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, rd_err, take_en = 1'b0;
    logic [5:0] irq_n_pin = 6'h3F; // pins idle high, driven as inputs only
    logic nmi_pin = 1'b1, cpu_mask = 1'b0, cpu_ack, req_valid, req_nmi, req_high;
    logic [26:0] periph_req = 27'h0;
    logic [7:0] cpu_ack_vec, req_vec;
    logic [15:0] req_addr;
    int mismatches = 0, cmp_count = 0, cyc = 0;
    always #5 pclk = ~pclk;
    eiesv_top uut (.pclk, .presetn, .hw_standby, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq_n_pin, .nmi_pin, .periph_req, .cpu_mask, .cpu_ack,
        .cpu_ack_vec, .req_valid, .req_nmi, .req_high, .req_vec, .req_addr);
    eiesv_cpu_model cpu (.pclk, .presetn, .take_en, .req_valid, .req_vec, .cpu_ack, .cpu_ack_vec);
    ////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // hang guard, far above the few hundred cycles needed
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer; idle cycle after so psel is never set twice at once
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    ////////////////////////////////////////////////////////////
    // reset values, spare bits, refused address, standby clear
    task automatic t_regs();
        rdchk(r_en, 32'h0);
        rdchk(r_sc, 32'h0);
        wr(r_en, 32'hC0);
        rdchk(r_en, 32'hC0);
        wr(r_sc, 32'hC0);
        rdchk(r_sc, 32'hC0);
        irq_n_pin <= 6'h00;
        tick(8);
        chk(req_valid, 32'h0);
        irq_n_pin <= 6'h3F;
        rdchk(r_st, 32'h3F);
        apb(1'b0, 8'h18, 32'h0);
        chk(rd_err, 32'h1);
        hw_standby <= 1'b1;
        tick(2);
        hw_standby <= 1'b0;
        rdchk(r_en, 32'h0);
        rdchk(r_sc, 32'h0);
    endtask
    // each line alone in level mode, then read-then-zero clear
    task automatic t_lines();
        for (int n = 0; n < 6; n++) begin
            wr(r_en, 32'h1 << n);
            irq_n_pin[n] <= 1'b0;
            tick(6);
            chk(req_vec, 12 + n);
            chk(req_addr, 2 * (12 + n));
            irq_n_pin[n] <= 1'b1;
            rdchk(r_st, 32'h1 << n);
            wr(r_st, 32'h0);
            tick(2);
            chk(req_valid, 32'h0);
        end
    endtask
    // edge mode: flag waits while disabled, cpu takes it, low level adds none
    task automatic t_edge();
        wr(r_en, 32'h0);
        wr(r_sc, 32'h04);
        irq_n_pin[2] <= 1'b0;
        tick(6);
        chk(req_valid, 32'h0);
        rdchk(r_st, 32'h04);
        wr(r_en, 32'h04);
        tick(2);
        chk(req_vec, 14);
        take_en <= 1'b1;
        tick(6);
        take_en <= 1'b0;
        chk(req_valid, 32'h0);
        rdchk(r_st, 32'h0);
        irq_n_pin[2] <= 1'b1;
    endtask
    // default order, levels, nmi on top, mask, nmi edge choice
    task automatic t_prio();
        wr(r_sc, 32'h0);
        wr(r_en, 32'h11);
        irq_n_pin <= 6'h2E;
        tick(6);
        chk(req_vec, 12);
        wr(r_p1, 32'h10);
        tick(1);
        chk(req_vec, 16);
        chk(req_high, 32'h1);
        wr(r_p1, 32'h90);
        tick(1);
        chk(req_vec, 12);
        periph_req[0] <= 1'b1;
        wr(r_p1, 32'h08);
        tick(1);
        chk(req_vec, 20);
        nmi_pin <= 1'b0;
        tick(6);
        chk(req_vec, 7);
        chk(req_addr, 16'h000E);
        chk(req_nmi, 32'h1);
        take_en <= 1'b1;
        tick(2);
        take_en <= 1'b0;
        tick(3);
        chk(req_vec, 20);
        cpu_mask <= 1'b1;
        wr(r_sy, 32'h03);
        chk(req_valid, 32'h0);
        nmi_pin <= 1'b1;
        tick(6);
        chk(req_addr, 16'h001C);
        take_en <= 1'b1;
        tick(6);
        take_en <= 1'b0;
        nmi_pin <= 1'b0;
        tick(6);
        chk(req_valid, 32'h0);
        cpu_mask <= 1'b0;
        wr(r_p1, 32'h00);
        tick(1);
        chk(req_vec, 12);
        periph_req[19] <= 1'b1;
        wr(r_p2, 32'h08);
        tick(1);
        chk(req_vec, 52);
        chk(req_high, 32'h1);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_lines();
        t_edge();
        t_prio();
        complete_run();
    end
endmodule
